// ==== shared/obt_pkg.sv ====
package obt_pkg;

    // Width of each data port.
    localparam int unsigned DATA_WIDTH = 8;

    // Direction encodings on the direction input.
    localparam logic DIR_ECL_TO_TTL = 1'b0;
    localparam logic DIR_TTL_TO_ECL = 1'b1;

    // Storage variant selection.
    localparam logic VARIANT_LATCH = 1'b0;
    localparam logic VARIANT_REGISTER = 1'b1;

    // Level of the ECL outputs while cut off.
    localparam logic [DATA_WIDTH-1:0] ECL_CUTOFF_VALUE = 8'h00;

    // Reset value of the stored data.
    localparam logic [DATA_WIDTH-1:0] STORE_RESET_VALUE = 8'h00;

    // Data present on both port sides.
    typedef struct packed {
        logic [DATA_WIDTH-1:0] ecl;
        logic [DATA_WIDTH-1:0] ttl;
    } obt_pair_s;

    // Drive towards both port sides.
    typedef struct packed {
        logic [DATA_WIDTH-1:0] ecl_data;
        logic ecl_active;
        logic [DATA_WIDTH-1:0] ttl_data;
        logic ttl_oe;
    } obt_drive_s;

endpackage

// ==== core/obt_store.sv ====
`timescale 1ns/1ps

// Storage stage: latch or register behaviour, captured on both sides at once.
module obt_store (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Control.
    input wire logic i_variant,
    input wire logic i_hold_capture_control,
    input wire logic i_capture_edge_clock,
    // Data.
    input wire obt_pkg::obt_pair_s i_pair,
    output obt_pkg::obt_pair_s o_pair
);

    typedef struct packed {
        obt_pkg::obt_pair_s held;
        logic clk_prev;
    } obt_store_state_s;

    obt_store_state_s state_reg;
    obt_store_state_s state_next;
    logic rise;

    // Rising edge of the sampled capture clock.
    assign rise = i_capture_edge_clock && !state_reg.clk_prev;

    // Next state of the storage for both variants.
    always_comb begin
        state_next = state_reg;
        state_next.clk_prev = i_capture_edge_clock;
        if (i_variant == obt_pkg::VARIANT_REGISTER) begin
            if (rise) begin
                state_next.held = i_pair;
            end
        end else if (!i_hold_capture_control) begin
            state_next.held = i_pair;
        end
    end

    // In the latch variant a low hold level passes inputs straight through; a high level freezes both sides.
    always_comb begin
        if (i_variant == obt_pkg::VARIANT_LATCH && !i_hold_capture_control) begin
            o_pair = i_pair;
        end else begin
            o_pair = state_reg.held;
        end
    end

    // State register.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= '{held: '{ecl: obt_pkg::STORE_RESET_VALUE, ttl: obt_pkg::STORE_RESET_VALUE},
                           clk_prev: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // Outside a rising edge the register variant keeps its captured word.
    a_reg_holds: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_variant == obt_pkg::VARIANT_REGISTER && !rise) |=> $stable(state_reg.held))
        else $error("Register variant changed stored data without a capture edge.");

    // A capture edge stores the inputs of both sides.
    a_reg_captures: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_variant == obt_pkg::VARIANT_REGISTER && rise) |=> (state_reg.held == $past(i_pair)))
        else $error("Register variant failed to capture on the capture edge.");

    // While held, the latch variant keeps both sides frozen.
    a_latch_freeze: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_variant == obt_pkg::VARIANT_LATCH && i_hold_capture_control && $past(i_hold_capture_control)
         && $stable(i_variant)) |-> $stable(o_pair))
        else $error("Latch variant output moved while held.");

endmodule

// ==== core/obt_translator.sv ====
`timescale 1ns/1ps

// Contract
// - Direction low passes ECL to TTL; direction high passes TTL to ECL.
// - Enable low cuts off ECL outputs and floats TTL outputs.
// - Latch variant: hold high freezes data from both sides.
// - Latch variant: hold low makes storage transparent.
// - Register variant updates only on capture clock rising edge.
// - Only the chosen side drives; storage captures both sides.
module obt_translator #(
    parameter logic VARIANT = obt_pkg::VARIANT_LATCH
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Control inputs.
    input wire logic i_direction,
    input wire logic i_output_enable,
    input wire logic i_hold_capture_control,
    input wire logic i_capture_edge_clock,
    // ECL side port.
    input wire logic [obt_pkg::DATA_WIDTH-1:0] i_ecl_side_port,
    output logic [obt_pkg::DATA_WIDTH-1:0] o_ecl_side_port,
    output logic o_ecl_side_active,
    // TTL side port.
    input wire logic [obt_pkg::DATA_WIDTH-1:0] i_ttl_side_port,
    output logic [obt_pkg::DATA_WIDTH-1:0] o_ttl_side_port,
    output logic o_ttl_side_port_oe
);

    // All state of the translator outside the storage stage is the registered drive towards both port sides.
    // Registering it keeps every output straight from a flip-flop.
    typedef struct packed {
        obt_pkg::obt_drive_s drive;
    } obt_state_s;

    // Registered drive, its next value, the sampled pins and the stored words.
    obt_state_s state_reg;
    obt_state_s state_next;
    obt_pkg::obt_pair_s in_pair;
    obt_pkg::obt_pair_s stored;

    // True when the TTL port is the one side allowed to drive.
    // One decode serves the drive logic and its checks, so the two cannot drift apart.
    function automatic logic ttl_selected(input logic enable, input logic direction);
        ttl_selected = enable && (direction == obt_pkg::DIR_ECL_TO_TTL);
    endfunction

    // True when the ECL port is the one side allowed to leave cut-off.
    // Both selections are false while the enable is low.
    function automatic logic ecl_selected(input logic enable, input logic direction);
        ecl_selected = enable && (direction == obt_pkg::DIR_TTL_TO_ECL);
    endfunction

    // Both sides are sampled together so storage holds both at once.
    assign in_pair = '{ecl: i_ecl_side_port, ttl: i_ttl_side_port};

    obt_store u_store (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_variant(VARIANT),
        .i_hold_capture_control(i_hold_capture_control),
        .i_capture_edge_clock(i_capture_edge_clock),
        .i_pair(in_pair),
        .o_pair(stored)
    );

    // Select the driven side and cross the stored data over to it.
    always_comb begin
        state_next.drive.ecl_data = obt_pkg::ECL_CUTOFF_VALUE;
        state_next.drive.ecl_active = 1'b0;
        state_next.drive.ttl_data = stored.ecl;
        state_next.drive.ttl_oe = 1'b0;
        if (ttl_selected(i_output_enable, i_direction)) begin
            state_next.drive.ttl_oe = 1'b1;
            state_next.drive.ttl_data = stored.ecl;
        end
        if (ecl_selected(i_output_enable, i_direction)) begin
            state_next.drive.ecl_active = 1'b1;
            state_next.drive.ecl_data = stored.ttl;
        end
    end

    // Output register.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= '{drive: '{ecl_data: obt_pkg::ECL_CUTOFF_VALUE, ecl_active: 1'b0,
                                    ttl_data: obt_pkg::STORE_RESET_VALUE, ttl_oe: 1'b0}};
        end else begin
            state_reg <= state_next;
        end
    end

    // Every output comes straight from the output register.
    assign o_ecl_side_port = state_reg.drive.ecl_data;
    assign o_ecl_side_active = state_reg.drive.ecl_active;
    assign o_ttl_side_port = state_reg.drive.ttl_data;
    assign o_ttl_side_port_oe = state_reg.drive.ttl_oe;

    // Disabled outputs stay cut off on both sides one cycle later.
    a_disable_cutoff: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        !i_output_enable |=> (!o_ttl_side_port_oe && !o_ecl_side_active
                              && o_ecl_side_port == obt_pkg::ECL_CUTOFF_VALUE))
        else $error("Outputs driven while output enable was low.");

    // Never both sides driven at once.
    a_one_side: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        !(o_ttl_side_port_oe && o_ecl_side_active))
        else $error("Both port sides driven together.");

    // Low direction drives the TTL side with the stored ECL data.
    a_dir_ecl_ttl: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_output_enable && i_direction == obt_pkg::DIR_ECL_TO_TTL)
        |=> (o_ttl_side_port_oe && o_ttl_side_port == $past(stored.ecl)))
        else $error("ECL to TTL translation wrong.");

    // High direction drives the ECL side with the stored TTL data.
    a_dir_ttl_ecl: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_output_enable && i_direction == obt_pkg::DIR_TTL_TO_ECL)
        |=> (o_ecl_side_active && o_ecl_side_port == $past(stored.ttl)))
        else $error("TTL to ECL translation wrong.");

    // Transparent latch passes the ECL input to the TTL outputs one cycle later.
    a_transparent: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (VARIANT == obt_pkg::VARIANT_LATCH && !i_hold_capture_control && i_output_enable
         && i_direction == obt_pkg::DIR_ECL_TO_TTL) |=> (o_ttl_side_port == $past(i_ecl_side_port)))
        else $error("Transparent latch did not follow input.");

    // The TTL enable is the registered decode of enable and direction.
    // Any other source could switch the TTL drivers on during a turnaround.
    a_ttl_enable_match: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        1'b1 |=> (o_ttl_side_port_oe == $past(ttl_selected(i_output_enable, i_direction))))
        else $error("TTL enable does not follow enable and direction.");

    // The ECL active flag is the registered decode of enable and direction.
    // With the enable high it rises and falls in the same cycle as the TTL enable falls and rises.
    a_ecl_enable_match: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        1'b1 |=> (o_ecl_side_active == $past(ecl_selected(i_output_enable, i_direction))))
        else $error("ECL active flag does not follow enable and direction.");

    // A low direction never lifts the ECL outputs out of cut-off.
    // This holds whatever the enable does, so a stray enable cannot fight the TTL side.
    a_low_dir_no_ecl: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_direction == obt_pkg::DIR_ECL_TO_TTL) |=> !o_ecl_side_active)
        else $error("ECL outputs active while direction was low.");

    // A high direction never turns the TTL drivers on.
    // The TTL pins then float and the outside logic may drive them.
    a_high_dir_no_ttl: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_direction == obt_pkg::DIR_TTL_TO_ECL) |=> !o_ttl_side_port_oe)
        else $error("TTL outputs driven while direction was high.");

    // With outputs enabled one side drives, so the chosen load never sees both sides idle.
    // Together with the one-side check this means exactly one side.
    a_enabled_drives: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        i_output_enable |=> (o_ttl_side_port_oe || o_ecl_side_active))
        else $error("No side driven while output enable was high.");

    // A chosen TTL side drives and the ECL side stays cut off in the same cycle.
    // The change of side is therefore never seen half done.
    a_ttl_side_alone: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        ttl_selected(i_output_enable, i_direction) |=> (o_ttl_side_port_oe && !o_ecl_side_active))
        else $error("TTL side chosen but drive flags wrong.");

    // Cut-off ECL outputs always show the cut-off level, whatever the stored data is.
    // Downstream logic may read the data lines without looking at the active flag first.
    a_ecl_cutoff_level: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        !o_ecl_side_active |-> (o_ecl_side_port == obt_pkg::ECL_CUTOFF_VALUE))
        else $error("Cut-off ECL outputs show data.");

    // The TTL data lines carry the stored ECL word even while floating.
    // Enabling the drivers then never exposes a stale word from an earlier direction.
    a_ttl_tracks_store: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        1'b1 |=> (o_ttl_side_port == $past(stored.ecl)))
        else $error("TTL data lines do not carry the stored ECL word.");

    // Two held cycles in a row leave the TTL data lines untouched in the latch variant.
    // The first held cycle still shows the last transparent word.
    a_latch_hold_ttl: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (VARIANT == obt_pkg::VARIANT_LATCH && i_hold_capture_control && $past(i_hold_capture_control))
        |=> $stable(o_ttl_side_port))
        else $error("Latch variant TTL data moved while held.");

    // The undriven side is frozen as well, so a turnaround after a hold shows held data.
    // Only the driven ECL outputs are watched; cut-off data is fixed anyway.
    a_latch_hold_ecl: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (VARIANT == obt_pkg::VARIANT_LATCH && i_hold_capture_control && $past(i_hold_capture_control)
         && ecl_selected(i_output_enable, i_direction) && $past(ecl_selected(i_output_enable, i_direction)))
        |=> $stable(o_ecl_side_port))
        else $error("Latch variant ECL data moved while held.");

    // A transparent latch passes the TTL input to the ECL outputs one cycle later.
    // This is the mirror of the ECL to TTL transparency check.
    a_transparent_ecl: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (VARIANT == obt_pkg::VARIANT_LATCH && !i_hold_capture_control
         && ecl_selected(i_output_enable, i_direction))
        |=> (o_ecl_side_port == $past(i_ttl_side_port)))
        else $error("Transparent latch did not pass TTL input to ECL side.");

    // Without a capture edge one cycle back the register variant keeps its TTL data.
    // The capture clock is sampled, so its edge is seen one cycle late and lands a cycle after that.
    a_reg_quiet_ttl: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (VARIANT == obt_pkg::VARIANT_REGISTER
         && !($past(i_capture_edge_clock) && !$past(i_capture_edge_clock, 2)))
        |=> $stable(o_ttl_side_port))
        else $error("Register variant TTL data moved without a capture edge.");

    // A capture edge one cycle back shows the ECL input of that cycle on the TTL side.
    // Both words are captured at that edge, whichever side is driven.
    a_reg_capture_ttl: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (VARIANT == obt_pkg::VARIANT_REGISTER && $past(i_capture_edge_clock) && !$past(i_capture_edge_clock, 2))
        |=> (o_ttl_side_port == $past(i_ecl_side_port, 2)))
        else $error("Register variant TTL data is not the captured ECL word.");

    // The same capture edge stores the TTL input for the ECL side.
    // It is checked only while the ECL side drives, since cut-off hides the data.
    a_reg_capture_ecl: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (VARIANT == obt_pkg::VARIANT_REGISTER && $past(i_capture_edge_clock) && !$past(i_capture_edge_clock, 2)
         && ecl_selected(i_output_enable, i_direction))
        |=> (o_ecl_side_port == $past(i_ttl_side_port, 2)))
        else $error("Register variant ECL data is not the captured TTL word.");

endmodule

// ==== testbench/obt_far_logic.sv ====
`timescale 1ns/1ps

// Far-side logic of both families, presenting the levels chosen by the bench.
module obt_far_logic (
    // Levels chosen by the bench.
    input wire obt_pkg::obt_pair_s i_level,
    // Pins seen by the translator.
    output obt_pkg::obt_pair_s o_pair
);
    // Both sides drive steadily, so storage always has defined data on each side.
    assign o_pair = i_level;
endmodule

// ==== testbench/test_obt_translator.sv ====
`timescale 1ns/1ps

// Latch and register variants share every input and are each checked against their own reference storage.
module test_obt_translator;
    localparam int W = obt_pkg::DATA_WIDTH;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic dir = 1'b0;
    logic oe = 1'b0;
    logic hold = 1'b0;
    logic cap = 1'b0;
    obt_pkg::obt_pair_s level = '0;
    obt_pkg::obt_pair_s pins;
    obt_pkg::obt_pair_s stored [2] = '{default: '0};
    logic [W-1:0] ecl_out [2];
    logic ecl_act [2];
    logic [W-1:0] ttl_out [2];
    logic ttl_oe [2];
    int bad_count = 0;
    int comparisons = 0;

    // Clock at 200 MHz.
    initial forever #2.5 i_clock = ~i_clock;

    obt_far_logic u_obt_far_logic (.i_level(level), .o_pair(pins));

    // Index 0 is the latch variant, index 1 the register variant.
    for (genvar v = 0; v < 2; v++) begin : g_variant
        obt_translator #(.VARIANT(v ? obt_pkg::VARIANT_REGISTER : obt_pkg::VARIANT_LATCH)) u_obt_translator (
            .i_clock(i_clock), .i_reset_n(i_reset_n), .i_direction(dir), .i_output_enable(oe),
            .i_hold_capture_control(hold), .i_capture_edge_clock(cap),
            .i_ecl_side_port(pins.ecl), .o_ecl_side_port(ecl_out[v]), .o_ecl_side_active(ecl_act[v]),
            .i_ttl_side_port(pins.ttl), .o_ttl_side_port(ttl_out[v]), .o_ttl_side_port_oe(ttl_oe[v]));
    end

    task automatic cmp_byte(input logic [W-1:0] got, input logic [W-1:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask

    // Drives one set of inputs, updates the reference storage, lets the outputs settle, checks both variants.
    task automatic apply(input logic d, input logic e, input logic h, input logic c,
                         input logic [W-1:0] ecl, input logic [W-1:0] ttl);
        @(posedge i_clock);
        if (!h) stored[0] = '{ecl: ecl, ttl: ttl};
        if (c && !cap) stored[1] = '{ecl: ecl, ttl: ttl};
        dir <= d;
        oe <= e;
        hold <= h;
        cap <= c;
        level <= '{ecl: ecl, ttl: ttl};
        repeat (3) @(posedge i_clock);
        #1;
        for (int v = 0; v < 2; v++) begin
            cmp_flag(ttl_oe[v], e & ~d, "ttl enable");
            cmp_flag(ecl_act[v], e & d, "ecl active");
            if (e & ~d) cmp_byte(ttl_out[v], stored[v].ecl, "ttl data");
            cmp_byte(ecl_out[v], (e & d) ? stored[v].ttl : obt_pkg::ECL_CUTOFF_VALUE, "ecl data");
        end
    endtask

    task automatic conclude();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Direction only changes while outputs are disabled.
    initial begin
        repeat (12) @(posedge i_clock);
        i_reset_n <= 1'b1;
        apply(1'b0, 1'b1, 1'b0, 1'b0, 8'hA5, 8'h3C);
        apply(1'b0, 1'b0, 1'b0, 1'b0, 8'hA5, 8'h3C);
        apply(1'b1, 1'b0, 1'b0, 1'b0, 8'hA5, 8'h3C);
        apply(1'b1, 1'b1, 1'b0, 1'b0, 8'hA5, 8'h3C);
        apply(1'b1, 1'b1, 1'b0, 1'b1, 8'h5A, 8'hC3);
        apply(1'b1, 1'b1, 1'b1, 1'b0, 8'h0F, 8'hF0);
        apply(1'b1, 1'b0, 1'b1, 1'b0, 8'h0F, 8'hF0);
        apply(1'b0, 1'b0, 1'b1, 1'b0, 8'h0F, 8'hF0);
        apply(1'b0, 1'b1, 1'b1, 1'b0, 8'h0F, 8'hF0);
        apply(1'b0, 1'b1, 1'b0, 1'b1, 8'h81, 8'h18);
        apply(1'b0, 1'b1, 1'b0, 1'b1, 8'h66, 8'h99);
        apply(1'b0, 1'b0, 1'b0, 1'b0, 8'h66, 8'h99);
        conclude();
    end

    // Twelve steps of four cycles each need well under this span.
    initial begin
        repeat (500) @(posedge i_clock);
        bad_count++;
        conclude();
    end
endmodule
